// ===== design/gsl_matrix.sv
// Purpose: Row-rotating scanner for a 3x3 indicator matrix
// Assumes: Row tick from a shared divider in the parent
// Notes: Outputs are registered, all low while disabled
`timescale 1ns/1ps
module gsl_matrix (
  input wire logic clk_i,     // System clock
  input wire logic resetn_i,  // Async reset, active low
  gsl_mx_if.scan mx           // Matrix carrier
);
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic [2:0] row_q;
  logic [2:0] col_q;
  logic [2:0] row_d;
  logic [2:0] col_d;

  // Next row index wraps after the third row
  assign idx_d = !mx.en ? 2'h0 :
                 !mx.tick ? idx_q :
                 (idx_q == 2'h2) ? 2'h0 : idx_q + 2'h1;
  assign row_d = mx.en ? (3'h1 << idx_d) : 3'h0;
  // Row-major placement, columns follow live status
  assign col_d = mx.en ? mx.led[3 * idx_d +: 3] : 3'h0;

  // Registered so the pins never glitch between rows
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_q <= 2'h0;
      row_q <= 3'h0;
      col_q <= 3'h0;
    end else begin
      idx_q <= idx_d;
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  assign mx.row = row_q;
  assign mx.col = col_q;

  property p_row_onehot;
    @(posedge clk_i) disable iff (!resetn_i)
    mx.en |=> $onehot(row_q);
  endproperty
  a_row_onehot: assert property (p_row_onehot)
    else $error("row lines not one at a time");

  property p_row_rotate;
    @(posedge clk_i) disable iff (!resetn_i)
    (mx.en && $past(mx.en) && mx.tick)
      |=> (row_q == {$past(row_q[1:0]), $past(row_q[2])});
  endproperty
  a_row_rotate: assert property (p_row_rotate)
    else $error("row did not rotate on tick");

  property p_col_map;
    @(posedge clk_i) disable iff (!resetn_i)
    (mx.en && row_q[1]) |-> ##1 (!mx.en || row_q[1] != 1'b1 ||
      col_q == $past(mx.led[5:3]) || mx.tick);
  endproperty
  a_col_map: assert property (p_col_map)
    else $error("middle row shows wrong channels");

  c_full_scan: cover property (@(posedge clk_i) disable iff (!resetn_i)
    row_q[0] ##[1:1000] row_q[1] ##[1:1000] row_q[2]);
endmodule

// ===== design/gsl_top.sv
// Purpose: Global supply/temperature status, fault pin and LED matrices
// Assumes: Inputs synchronous to clk_i; resetn_i is the supply lockout
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module gsl_top #(
  parameter int BLANK_CYCLES = gsl_pkg::BLANK_CYC,
  parameter int SUPPR_CYCLES = gsl_pkg::SUPPR_CYC,
  parameter int ROW_CYCLES = gsl_pkg::ROW_CYC
) (
  input wire logic clk_i,                       // 125 MHz clock
  input wire logic resetn_i,                    // Lockout, active low
  input wire logic [7:0] addr_i,                // Register index
  input wire logic [7:0] wdata_i,               // Write data
  input wire logic wr_i,                        // Write strobe
  input wire logic rd_i,                        // Read strobe
  output logic [7:0] rdata_o,                   // Read data, next cycle
  input wire logic supply_low_cmp_i,            // Undervoltage comparator
  input wire logic supply_absent_cmp_i,         // Missing-voltage comparator
  input wire logic reset_level_i,               // Power-side reset level
  input wire logic overtemp_i,                  // Chip overtemperature
  input wire logic link_error_i,                // Isolation link error
  input wire logic output_kill_pin_i,           // Common disable
  input wire logic [7:0] channel_overheat_i,    // Thermal shutdown
  input wire logic [7:0] channel_current_limit_i, // Overcurrent
  input wire logic [7:0] cold_lamp_i,           // Inrush load seen
  input wire logic sel_pin_i,                   // Interface select
  input wire logic access_cfg_pin1_i,           // Access mode pin 1
  input wire logic access_cfg_pin0_i,           // Access mode pin 0
  output logic [7:0] drive_o,                   // Switch gate drives
  output logic err_n_o,                         // Fault pin, active low
  output logic [2:0] process_row_line_o,        // Power matrix rows
  output logic [2:0] process_col_line_o,        // Power matrix columns
  output logic [7:0] host_bus_lines_o,          // Host lines, out level
  output logic [7:0] host_bus_lines_oe_n_o,     // Host lines, low drives
  output logic latch_pin_o,                     // Latch/reset pin level
  output logic latch_pin_oe_n_o,                // Latch/reset enable
  output logic wr_pin_o,                        // Write strobe pin level
  output logic wr_pin_oe_n_o,                   // Write strobe enable
  output logic hw_reset_en_o                    // Latch pin resets chip
);
  localparam int BW = $clog2(BLANK_CYCLES + 1);
  localparam int SW = $clog2(SUPPR_CYCLES + 1);
  localparam int RW = $clog2(ROW_CYCLES + 1);
  localparam int GW = gsl_pkg::GF_W;
  localparam int NCH = gsl_pkg::CHANNELS;

  // Configuration sampled once after lockout release
  gsl_pkg::gsl_cfg_t cfg_state_q;
  logic serial_q;
  logic [1:0] mode_q;
  logic cfg_done;
  assign cfg_done = (cfg_state_q == gsl_pkg::GSL_CFG_RUN);

  // Pins caught by a clocked process, never by the async reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_state_q <= gsl_pkg::GSL_CFG_SAMPLE;
      serial_q <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      case (cfg_state_q)
        gsl_pkg::GSL_CFG_SAMPLE: begin
          serial_q <= sel_pin_i;
          mode_q <= {access_cfg_pin1_i, access_cfg_pin0_i};
          cfg_state_q <= gsl_pkg::GSL_CFG_RUN;
        end
        gsl_pkg::GSL_CFG_RUN: cfg_state_q <= gsl_pkg::GSL_CFG_RUN;
        default: cfg_state_q <= gsl_pkg::GSL_CFG_SAMPLE;
      endcase
    end
  end

  // Host access only once configured
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = wr_i && cfg_done;
  assign rd_ok = rd_i && cfg_done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Comparator blanking: a level must stand BLANK_CYCLES to count
  logic [1:0] cmp_raw;
  logic [1:0] cmp_last_q;
  logic [1:0] cmp_filt_q;
  assign cmp_raw = {supply_absent_cmp_i, supply_low_cmp_i};
  for (genvar k = 0; k < 2; k++) begin : g_blank
    logic [BW-1:0] cnt_q;
    logic same;
    logic full;
    assign same = (cmp_raw[k] == cmp_last_q[k]);
    assign full = (cnt_q == BW'(BLANK_CYCLES - 1));
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cnt_q <= '0;
        cmp_last_q[k] <= 1'b1;
        cmp_filt_q[k] <= 1'b1;
      end else begin
        cmp_last_q[k] <= cmp_raw[k];
        cnt_q <= !same ? '0 : (full ? cnt_q : cnt_q + BW'(1));
        if (same && full) begin
          cmp_filt_q[k] <= cmp_raw[k];
        end
      end
    end
  end

  // Registers written by software
  logic [7:0] cfg_q;
  logic [7:0] drive_reg_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= gsl_pkg::CFG_RESET;
      drive_reg_q <= gsl_pkg::DRIVE_RESET;
    end else begin
      if (wr_ok && hit(addr_i, gsl_pkg::ADDR_GLOBAL_CONFIG)) begin
        cfg_q <= wdata_i;
      end
      if (wr_ok && hit(addr_i, gsl_pkg::ADDR_DRIVE)) begin
        drive_reg_q <= wdata_i;
      end
    end
  end

  // Power side goes dark once absent supply reaches reset level
  logic pwr_off_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_off_q <= 1'b0;
    end else if (cmp_filt_q[1] && reset_level_i) begin
      pwr_off_q <= 1'b1;
    end else if (!cmp_filt_q[1]) begin
      pwr_off_q <= 1'b0;
    end
  end

  // Drives: overcurrent only holds off, restart is automatic
  logic [7:0] drive_d;
  logic [7:0] drive_q;
  logic [7:0] trip;
  assign trip = channel_overheat_i | channel_current_limit_i;
  assign drive_d = (pwr_off_q || output_kill_pin_i) ? 8'h00 :
                   drive_reg_q & ~trip;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_q <= 8'h00;
    end else begin
      drive_q <= drive_d;
    end
  end

  // Global flags: set by the live condition, refreshed by a read
  logic [GW-1:0] gf_cond;
  logic [GW-1:0] gf_q;
  logic refresh;
  assign gf_cond[gsl_pkg::GF_LOW] = cmp_filt_q[0];
  assign gf_cond[gsl_pkg::GF_ABSENT] = cmp_filt_q[1];
  assign gf_cond[gsl_pkg::GF_HOT] = overtemp_i;
  assign gf_cond[gsl_pkg::GF_DEAD] = (drive_q == 8'h00);
  assign gf_cond[gsl_pkg::GF_LAMP] = |cold_lamp_i;
  assign gf_cond[gsl_pkg::GF_LINK] = link_error_i;
  assign refresh = rd_ok && (hit(addr_i, gsl_pkg::ADDR_GLOBAL_FAULT) ||
                             hit(addr_i, gsl_pkg::ADDR_CHANNEL_FAULT));

  // Preset high so the fault pin starts low; set beats refresh
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gf_q <= gsl_pkg::GF_RESET;
    end else if (refresh) begin
      gf_q <= gf_cond;
    end else begin
      gf_q <= gf_q | gf_cond;
    end
  end

  // Channel faults are sticky until read; a new event wins the clear
  logic [7:0] cf_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cf_q <= 8'h00;
    end else if (refresh) begin
      cf_q <= trip;
    end else begin
      cf_q <= cf_q | trip;
    end
  end

  // Fault pin from the flags that feed fault generation
  logic err_n_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_n_q <= 1'b0;
    end else begin
      err_n_q <= !(gf_q[gsl_pkg::GF_LOW] || gf_q[gsl_pkg::GF_ABSENT] ||
                   gf_q[gsl_pkg::GF_LINK]);
    end
  end

  // Gate bits hide thermal toggling from the indicators
  logic [7:0] gate_q;
  for (genvar c = 0; c < NCH; c++) begin : g_gate
    logic [SW-1:0] hold_q;
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        hold_q <= '0;
        gate_q[c] <= 1'b1;
      end else begin
        if (trip[c]) begin
          hold_q <= SW'(SUPPR_CYCLES);
        end else if (hold_q != '0) begin
          hold_q <= hold_q - SW'(1);
        end
        gate_q[c] <= !trip[c] && (hold_q == '0);
      end
    end
  end

  // Indicator status made on power side, then one link stage
  logic [7:0] ind_pwr;
  logic [7:0] ind_link_q;
  assign ind_pwr = drive_q & gate_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ind_link_q <= 8'h00;
    end else begin
      ind_link_q <= ind_pwr;
    end
  end

  // Shared row divider; one tick a third of a scan period
  logic [RW-1:0] div_q;
  logic tick;
  assign tick = (div_q == RW'(ROW_CYCLES - 1));
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + RW'(1);
    end
  end

  // Host matrix needs serial mode and the enable bit
  logic host_led;
  assign host_led = cfg_done && serial_q &&
                    cfg_q[gsl_pkg::CFG_HOST_LED];

  gsl_mx_if pmx ();
  gsl_mx_if hmx ();
  assign pmx.tick = tick;
  assign pmx.en = !pwr_off_q;
  assign pmx.led = {1'b0, ind_pwr};
  assign hmx.tick = tick;
  assign hmx.en = host_led;
  assign hmx.led = {!err_n_q, ind_link_q};

  gsl_matrix u_pmx (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .mx(pmx.scan)
  );
  gsl_matrix u_hmx (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .mx(hmx.scan)
  );

  // Host pin reuse; lines stay undriven until configured
  logic [7:0] hb_d;
  logic [7:0] hb_oe_n_d;
  logic [7:0] hb_q;
  logic [7:0] hb_oe_n_q;
  logic [3:0] pins_q;
  logic hwr_q;
  always_comb begin
    hb_d = 8'h00;
    hb_oe_n_d = 8'hff;
    if (host_led) begin
      hb_d[gsl_pkg::HB_COL2] = hmx.col[2];
      hb_d[gsl_pkg::HB_ROW2] = hmx.row[2];
      hb_d[gsl_pkg::HB_ROW1] = hmx.row[1];
      hb_d[gsl_pkg::HB_ROW0] = hmx.row[0];
      hb_oe_n_d[gsl_pkg::HB_COL2] = 1'b0;
      hb_oe_n_d[gsl_pkg::HB_ROW2] = 1'b0;
      hb_oe_n_d[gsl_pkg::HB_ROW1] = 1'b0;
      hb_oe_n_d[gsl_pkg::HB_ROW0] = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hb_q <= 8'h00;
      hb_oe_n_q <= 8'hff;
      pins_q <= 4'hf;
      hwr_q <= 1'b1;
    end else begin
      hb_q <= hb_d;
      hb_oe_n_q <= hb_oe_n_d;
      pins_q <= host_led ? {hmx.col[1], 1'b0, hmx.col[0], 1'b0} :
                           4'h5;
      hwr_q <= !host_led;
    end
  end

  // Read mux; unmapped indices read zero
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  assign rd_mux =
    hit(addr_i, gsl_pkg::ADDR_GLOBAL_FAULT) ? {2'h0, gf_q} :
    hit(addr_i, gsl_pkg::ADDR_CHANNEL_FAULT) ? cf_q :
    hit(addr_i, gsl_pkg::ADDR_GLOBAL_CONFIG) ? cfg_q :
    hit(addr_i, gsl_pkg::ADDR_DRIVE) ? drive_reg_q :
    hit(addr_i, gsl_pkg::ADDR_GATE) ? gate_q :
    hit(addr_i, gsl_pkg::ADDR_IF_STATUS) ?
      {4'h0, cfg_done, mode_q, serial_q} : 8'h00;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_ok ? rd_mux : 8'h00;
    end
  end

  assign rdata_o = rdata_q;
  assign drive_o = drive_q;
  assign err_n_o = err_n_q;
  assign process_row_line_o = pmx.row;
  assign process_col_line_o = pmx.col;
  assign host_bus_lines_o = hb_q;
  assign host_bus_lines_oe_n_o = hb_oe_n_q;
  assign latch_pin_o = pins_q[3];
  assign latch_pin_oe_n_o = pins_q[2];
  assign wr_pin_o = pins_q[1];
  assign wr_pin_oe_n_o = pins_q[0];
  assign hw_reset_en_o = hwr_q;

  property p_cfg_first;
    @(posedge clk_i) disable iff (!resetn_i)
    !cfg_done |=> cfg_done;
  endproperty
  a_cfg_first: assert property (p_cfg_first)
    else $error("configuration not done one cycle after release");

  property p_bus_float;
    @(posedge clk_i) disable iff (!resetn_i)
    !cfg_done |-> (host_bus_lines_oe_n_o == 8'hff) && !err_n_o;
  endproperty
  a_bus_float: assert property (p_bus_float)
    else $error("host lines driven or fault released before config");

  property p_err_low;
    @(posedge clk_i) disable iff (!resetn_i)
    (gf_q[gsl_pkg::GF_LOW] || gf_q[gsl_pkg::GF_ABSENT] ||
     gf_q[gsl_pkg::GF_LINK]) |=> !err_n_o;
  endproperty
  a_err_low: assert property (p_err_low)
    else $error("fault pin high with a fault flag set");

  property p_refresh;
    @(posedge clk_i) disable iff (!resetn_i)
    (refresh && gf_cond == '0) |=> (gf_q == '0) ##1 err_n_o;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("read did not refresh preset flags");

  property p_overcurrent_off;
    @(posedge clk_i) disable iff (!resetn_i)
    (channel_current_limit_i != 8'h00)
      |=> ((drive_o & $past(channel_current_limit_i)) == 8'h00);
  endproperty
  a_overcurrent_off: assert property (p_overcurrent_off)
    else $error("switch on during overcurrent");

  property p_gate_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(trip[0]) |=> !gate_q[0] [*8];
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gate bit released too early");

  property p_dead;
    @(posedge clk_i) disable iff (!resetn_i)
    (drive_q == 8'h00) |=> gf_q[gsl_pkg::GF_DEAD];
  endproperty
  a_dead: assert property (p_dead)
    else $error("outputs-dead flag missing");

  property p_hw_reset;
    @(posedge clk_i) disable iff (!resetn_i)
    host_led |=> !hw_reset_en_o;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("hardware reset left enabled with host matrix");

  property p_low_set;
    @(posedge clk_i) disable iff (!resetn_i)
    cmp_filt_q[0] |=> gf_q[gsl_pkg::GF_LOW];
  endproperty
  a_low_set: assert property (p_low_set)
    else $error("supply-low flag not set");

  c_release: cover property (@(posedge clk_i) disable iff (!resetn_i)
    refresh ##2 err_n_o);
  c_host_led: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(host_led));
  c_pwr_off: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(pwr_off_q));
endmodule

// ===== pkg/gsl_mx_if.sv
// Purpose: Carrier between status logic and a matrix scanner
// Assumes: Single clock, tick is a one-cycle enable
// Notes: led index is row*3+col
`timescale 1ns/1ps
interface gsl_mx_if;
  logic tick;
  logic en;
  logic [8:0] led;
  logic [2:0] row;
  logic [2:0] col;
  modport scan (input tick, input en, input led, output row, output col);
  modport drv (output tick, output en, output led, input row, input col);
endinterface

// ===== pkg/gsl_pkg.sv
// Purpose: Shared constants for the global status and indicator block
// Assumes: 125 MHz system clock, 8-bit register port
// Notes: Register offsets are word indices on the plain port
// Behaviour
// - Raise supply-low flag when supply monitor reports supply below undervoltage level.
// - Raise supply-absent flag when supply monitor reports supply below missing level.
// - Raise overtemperature flag on chip overheat; it never shuts outputs down.
// - Outputs-dead flag set whenever every driver is off, whatever the cause.
// - Lamp flag set whenever any driver load behaves like a cold lamp.
// - During lockout registers hold reset; link, low, absent flags high, fault low.
// - After reset release sample select and access pins before serving host.
// - Power up as parallel device, host lines undriven until configured.
// - Ignore comparator changes shorter than the 2 ms blanking interval.
// - Supply low sets its global fault bit; outputs keep working.
// - Supply absent sets its bit; power side off at reset level.
// - Switch stays off during overcurrent, turns back on when it ends.
// - Fault register reads refresh preset status bits, releasing the fault pin.
// - Indicator drive is channel output bit AND its gate bit.
// - Overheat or overcurrent clears gate bit for at least 100 ms.
// - Indicator signals made on power side, carried over the link.
// - Power matrix lights channel only when on, not overheated, not limiting.
// - Rows active one at a time, each a third of a 1000 Hz scan.
// - Host matrix runs only with its enable bit set in serial mode.
// - Host matrix enable disables hardware reset of the latch pin.
// - Host matrix reuses bus line 1, latch, write, lines 2, 3, 6.
// - Ninth host matrix position shows the inverted fault indication.
package gsl_pkg;
  // Timing figures in their own units, then cycle counts
  localparam int CLK_HZ = 125_000_000;
  localparam int BLANK_US = 2000;
  localparam int BLANK_CYC = CLK_HZ / 1_000_000 * BLANK_US;
  localparam int SUPPR_MS = 100;
  localparam int SUPPR_CYC = CLK_HZ / 1000 * SUPPR_MS;
  localparam int SCAN_HZ = 1000;
  localparam int ROWS = 3;
  localparam int ROW_CYC = CLK_HZ / (SCAN_HZ * ROWS);
  localparam int CHANNELS = 8;
  localparam int SPOTS = 9;

  // Register indices
  localparam logic [7:0] ADDR_GLOBAL_FAULT = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL_FAULT = 8'h01;
  localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_DRIVE = 8'h03;
  localparam logic [7:0] ADDR_GATE = 8'h04;
  localparam logic [7:0] ADDR_IF_STATUS = 8'h05;

  // Global fault register fields
  localparam int GF_LOW = 0;
  localparam int GF_ABSENT = 1;
  localparam int GF_HOT = 2;
  localparam int GF_DEAD = 3;
  localparam int GF_LAMP = 4;
  localparam int GF_LINK = 5;
  localparam int GF_W = 6;
  localparam logic [5:0] GF_RESET = 6'h23;

  // Global config field and interface status fields
  localparam int CFG_HOST_LED = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam int IFS_SERIAL = 0;
  localparam int IFS_MODE0 = 1;
  localparam int IFS_MODE1 = 2;
  localparam int IFS_DONE = 3;

  // Host pin positions reused by the host matrix
  localparam int HB_COL2 = 1;
  localparam int HB_ROW2 = 2;
  localparam int HB_ROW1 = 3;
  localparam int HB_ROW0 = 6;

  typedef enum logic {GSL_CFG_SAMPLE, GSL_CFG_RUN} gsl_cfg_t;
endpackage

// ===== tb/gsl_host_leds.sv
// Purpose: Host-side wiring with the indicator matrix on host pins
// Assumes: No pulls; a released line drifts to the inverse of its last level
// Notes: Row and column levels decoded from the resolved wires
`timescale 1ns/1ps
module gsl_host_leds (
  input wire logic clk_i,            // Clock
  input wire logic [7:0] bus_i,      // Bus line levels
  input wire logic [7:0] bus_oe_n_i, // Bus enables, low drives
  input wire logic latch_i,          // Latch pin level
  input wire logic latch_oe_n_i,     // Latch pin enable
  input wire logic wr_i,             // Write pin level
  input wire logic wr_oe_n_i,        // Write pin enable
  output logic [2:0] row_o,          // Row levels 2..0
  output logic [2:0] col_o           // Column levels 2..0
);
  logic [9:0] last_q = 10'h000;
  logic [9:0] drv;
  logic [9:0] oe_n;
  logic [9:0] lvl;
  // Undriven lines never keep a stale level the bench could trust
  assign drv = {latch_i, wr_i, bus_i};
  assign oe_n = {latch_oe_n_i, wr_oe_n_i, bus_oe_n_i};
  assign lvl = (drv & ~oe_n) | (~last_q & oe_n);
  assign row_o = {lvl[2], lvl[3], lvl[6]};
  assign col_o = {lvl[1], lvl[9], lvl[8]};
  // Remember each wire level
  always_ff @(posedge clk_i) begin
    last_q <= lvl;
  end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the global status block
// Assumes: Shortened counts, serial strap first, parallel after a reset
// Notes: One task per scenario, each judges its own results
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, drive_o;
  logic wr_i = 1'b0, rd_i = 1'b0, low = 1'b0, absent = 1'b0, rlev = 1'b0;
  logic hot = 1'b0, link = 1'b0, kill = 1'b0, err_n_o, hw_reset_en_o;
  logic [7:0] oh = 8'h00, oc = 8'h00, lamp = 8'h00, hb, hb_oe_n;
  logic [2:0] p_row, p_col, h_row, h_col;
  logic lat, lat_oe_n, wrp, wrp_oe_n, sel = 1'b1;
  logic [1:0] ms = 2'h0;
  int errors = 0, compares = 0, cycles = 0;
  gsl_top #(.BLANK_CYCLES(8), .SUPPR_CYCLES(20), .ROW_CYCLES(4)) i_gsl_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .supply_low_cmp_i(low),
    .supply_absent_cmp_i(absent), .reset_level_i(rlev), .overtemp_i(hot),
    .link_error_i(link), .output_kill_pin_i(kill),
    .channel_overheat_i(oh), .channel_current_limit_i(oc),
    .cold_lamp_i(lamp), .sel_pin_i(sel), .access_cfg_pin1_i(ms[1]),
    .access_cfg_pin0_i(ms[0]), .drive_o(drive_o), .err_n_o(err_n_o),
    .process_row_line_o(p_row), .process_col_line_o(p_col),
    .host_bus_lines_o(hb), .host_bus_lines_oe_n_o(hb_oe_n),
    .latch_pin_o(lat), .latch_pin_oe_n_o(lat_oe_n), .wr_pin_o(wrp),
    .wr_pin_oe_n_o(wrp_oe_n), .hw_reset_en_o(hw_reset_en_o));
  gsl_host_leds i_gsl_host_leds (.clk_i(clk_i), .bus_i(hb),
    .bus_oe_n_i(hb_oe_n), .latch_i(lat), .latch_oe_n_i(lat_oe_n),
    .wr_i(wrp), .wr_oe_n_i(wrp_oe_n), .row_o(h_row), .col_o(h_col));
  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, exp, input logic [7:0] m = 8'hff);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, exp, "read data");
  endtask
  // Bounded wait for a row, then judge its columns
  task automatic row(input logic [2:0] r, c, input logic host);
    int n;
    n = 0;
    while (((host ? h_row : p_row) !== r) && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk(host ? h_col : p_col, c, "matrix columns");
  endtask
  task automatic t_boot();
    chk(err_n_o, 1'b0, "fault pin");
    chk(hb_oe_n, 8'hff, "bus enables");
    resetn_i <= 1'b1;
    cyc(16);
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h2b);
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h08);
    cyc(1);
    chk(err_n_o, 1'b1, "fault pin");
    rd(gsl_pkg::ADDR_IF_STATUS, 8'h09);
    $display("boot done");
  endtask
  task automatic t_supply();
    wr(gsl_pkg::ADDR_DRIVE, 8'hff);
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h08);
    low <= 1'b1;
    cyc(4);
    low <= 1'b0;
    cyc(16);
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h00);
    low <= 1'b1;
    cyc(16);
    chk(err_n_o, 1'b0, "fault pin");
    chk(drive_o, 8'hff, "drives");
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h01);
    low <= 1'b0;
    absent <= 1'b1;
    rlev <= 1'b1;
    cyc(16);
    chk(drive_o, 8'h00, "drives");
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h02, 8'h02);
    absent <= 1'b0;
    rlev <= 1'b0;
    cyc(16);
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h0a);
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h00, 8'hf7);
    $display("supply done");
  endtask
  task automatic t_globals();
    wr(gsl_pkg::ADDR_DRIVE, 8'hff);
    hot <= 1'b1;
    lamp <= 8'h20;
    link <= 1'b1;
    cyc(3);
    chk(drive_o, 8'hff, "drives");
    chk(err_n_o, 1'b0, "fault pin");
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h34, 8'h34);
    {hot, link, lamp, kill} <= {10'h000, 1'b1};
    cyc(3);
    chk(drive_o, 8'h00, "drives");
    rd(gsl_pkg::ADDR_GLOBAL_FAULT, 8'h3c);
    kill <= 1'b0;
    $display("globals done");
  endtask
  task automatic t_trip();
    oc <= 8'h04;
    cyc(3);
    chk(drive_o, 8'hfb, "drives");
    row(3'b001, 3'b011, 1'b0);
    oc <= 8'h00;
    cyc(3);
    chk(drive_o, 8'hff, "drives");
    rd(gsl_pkg::ADDR_GATE, 8'hfb);
    cyc(30);
    rd(gsl_pkg::ADDR_GATE, 8'hff);
    row(3'b001, 3'b111, 1'b0);
    row(3'b100, 3'b011, 1'b0);
    oh <= 8'h80;
    cyc(3);
    row(3'b100, 3'b001, 1'b0);
    rd(gsl_pkg::ADDR_CHANNEL_FAULT, 8'h80, 8'h80);
    oh <= 8'h00;
    cyc(30);
    $display("trip done");
  endtask
  task automatic t_host();
    wr(gsl_pkg::ADDR_GLOBAL_CONFIG, 8'h01);
    cyc(4);
    chk(hw_reset_en_o, 1'b0, "hw reset");
    chk(lat_oe_n, 1'b0, "latch enable");
    row(3'b100, 3'b011, 1'b1);
    link <= 1'b1;
    cyc(4);
    row(3'b100, 3'b111, 1'b1);
    link <= 1'b0;
    wr(gsl_pkg::ADDR_GLOBAL_CONFIG, 8'h00);
    cyc(4);
    chk(hw_reset_en_o, 1'b1, "hw reset");
    $display("host done");
  endtask
  // Mid-run lockout, parallel strap: host matrix must stay off
  task automatic t_parallel();
    sel <= 1'b0;
    ms <= 2'h3;
    resetn_i <= 1'b0;
    cyc(3);
    chk(err_n_o, 1'b0, "fault pin");
    chk(hb_oe_n, 8'hff, "bus enables");
    resetn_i <= 1'b1;
    cyc(3);
    rd(gsl_pkg::ADDR_IF_STATUS, 8'h0e);
    wr(gsl_pkg::ADDR_GLOBAL_CONFIG, 8'h01);
    cyc(4);
    chk(hw_reset_en_o, 1'b1, "hw reset");
    chk(lat_oe_n, 1'b1, "latch enable");
    $display("parallel done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(20);
    t_boot();
    t_supply();
    t_globals();
    t_trip();
    t_host();
    t_parallel();
    report_and_stop();
  end
endmodule
